// ==== src/sbn_core.v ====
// Socket buffer allocation, address translation, retry control and network settings.
// Assumes synchronous configuration inputs from firmware logic on the same clock.
//
// Function
// (RL1) Sizes 1, 2, 4, 8, 16 KB accepted
// (RL2) Firmware keeps each region total within 16KB
// (RL3) Transmit region starts at 0xFE8000
// (RL4) Receive region starts at 0xFEC000
// (RL5) Socket bases packed contiguously in order
// (RL6) Offset mask equals buffer size minus one
// (RL7) Retry interval counted in 100 us units
// (RL8) Failed sends retried up to attempt count
// (RL9) Firmware sets irq threshold at least 0x2B00
// (RL10) Firmware computes timer 2 reload value
// (RL11) Eight independent sockets used concurrently
// (RL12) Echo requests answered automatically after init
// (RL13) Server socket waits, accepts connection passively
// (RL14) Client socket sends connection request first
// (RL15) Firmware programs unique hardware address
// (RL16) Physical address is base plus masked pointer
// (RL17) Accesses wrap inside the socket buffer
`include "sbn_map.vh"
module sbn_core (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // Buffer size configuration, one byte per socket, value in KB
    input wire [63:0] sock_tx_buf_size_i,
    input wire [63:0] sock_rx_buf_size_i,
    input wire cfg_load_i,
    // Buffer access translation
    input wire [2:0] acc_sock_i,
    input wire acc_is_rx_i,
    input wire [15:0] acc_ptr_i,
    input wire [15:0] acc_len_i,
    output reg [23:0] acc_phys_o,
    output reg [15:0] acc_first_len_o,
    output reg acc_wraps_o,
    // Derived layout, per socket
    output wire [191:0] sock_tx_base_o,
    output wire [191:0] sock_rx_base_o,
    output wire [127:0] sock_tx_offset_mask_o,
    output wire [127:0] sock_rx_offset_mask_o,
    output wire [7:0] size_err_o,
    output wire [1:0] total_err_o,
    // Network settings
    input wire [47:0] local_hw_addr_i,
    input wire [31:0] gateway_ip_i,
    input wire [31:0] netmask_i,
    input wire [31:0] local_ip_i,
    input wire [15:0] retry_interval_i,
    input wire [7:0] retry_attempts_i,
    input wire [15:0] core_irq_threshold_i,
    input wire net_load_i,
    output reg [47:0] local_hw_addr_o,
    output reg [31:0] gateway_ip_o,
    output reg [31:0] netmask_o,
    output reg [31:0] local_ip_o,
    output reg [15:0] core_irq_threshold_o,
    output reg init_done_o,
    // Echo reply, per socket open handling
    input wire echo_req_i,
    output reg echo_reply_o,
    input wire [7:0] sock_open_i,
    input wire [7:0] sock_server_i,
    input wire [7:0] conn_req_rx_i,
    output reg [7:0] conn_accept_o,
    output reg [7:0] conn_req_tx_o,
    // Transmission retry
    input wire tx_fail_i,
    input wire tx_ok_i,
    output reg resend_o,
    output reg retry_fail_o,
    output reg retry_busy_o
);
    // ------------------------------------------------------------
    // Size decoding
    // ------------------------------------------------------------
    // (RL1) legal size check
    function size_ok;
        input [7:0] kb;
        begin
            size_ok = (kb == 8'h01) || (kb == 8'h02) || (kb == 8'h04) || (kb == 8'h08) || (kb == 8'h10);
        end
    endfunction

    // Illegal codes fall back to 1 KB so the layout stays within its region.
    function [16:0] size_bytes;
        input [7:0] kb;
        begin
            if (size_ok(kb))
                size_bytes = {kb[4:0], 12'h000} >> 2;
            else
                size_bytes = 17'h00400;
        end
    endfunction

    reg [63:0] tx_size_ff;
    reg [63:0] rx_size_ff;
    wire [16:0] tx_bytes [0:7];
    wire [16:0] rx_bytes [0:7];
    wire [17:0] tx_acc [0:8];
    wire [17:0] rx_acc [0:8];

    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            tx_size_ff <= {8{`SBN_SIZE_RST}};
            rx_size_ff <= {8{`SBN_SIZE_RST}};
        end
        else if (cfg_load_i)
        begin
            tx_size_ff <= sock_tx_buf_size_i;
            rx_size_ff <= sock_rx_buf_size_i;
        end
    end

    assign tx_acc[0] = 18'h00000;
    assign rx_acc[0] = 18'h00000;

    // ------------------------------------------------------------
    // Per socket layout
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `SBN_NUM_SOCK; g = g + 1)
        begin : g_sock
            assign tx_bytes[g] = size_bytes(tx_size_ff[8*g+7:8*g]);
            assign rx_bytes[g] = size_bytes(rx_size_ff[8*g+7:8*g]);
            // (RL5) base is previous base plus previous size
            assign tx_acc[g+1] = tx_acc[g] + {1'b0, tx_bytes[g]};
            assign rx_acc[g+1] = rx_acc[g] + {1'b0, rx_bytes[g]};
            // (RL3) transmit region origin
            assign sock_tx_base_o[24*g+23:24*g] = `SBN_TX_REGION_BASE + {6'h00, tx_acc[g]};
            // (RL4) receive region origin
            assign sock_rx_base_o[24*g+23:24*g] = `SBN_RX_REGION_BASE + {6'h00, rx_acc[g]};
            // (RL6) mask is size minus one
            assign sock_tx_offset_mask_o[16*g+15:16*g] = tx_bytes[g][15:0] - 16'h0001;
            assign sock_rx_offset_mask_o[16*g+15:16*g] = rx_bytes[g][15:0] - 16'h0001;
            assign size_err_o[g] = !size_ok(tx_size_ff[8*g+7:8*g]) || !size_ok(rx_size_ff[8*g+7:8*g]);
        end
    endgenerate

    // Overcommitted totals are flagged, not corrected; keeping them legal is firmware's job.
    assign total_err_o[0] = tx_acc[8] > {1'b0, `SBN_REGION_BYTES};
    assign total_err_o[1] = rx_acc[8] > {1'b0, `SBN_REGION_BYTES};

    // ------------------------------------------------------------
    // Access translation
    // ------------------------------------------------------------
    reg [23:0] sel_base;
    reg [15:0] sel_mask;
    reg [15:0] off;
    reg [16:0] room;
    always @*
    begin
        sel_base = 24'h000000;
        sel_mask = 16'h0000;
        if (acc_is_rx_i)
        begin
            sel_base = sock_rx_base_o[24*acc_sock_i +: 24];
            sel_mask = sock_rx_offset_mask_o[16*acc_sock_i +: 16];
        end
        else
        begin
            sel_base = sock_tx_base_o[24*acc_sock_i +: 24];
            sel_mask = sock_tx_offset_mask_o[16*acc_sock_i +: 16];
        end
        off = acc_ptr_i & sel_mask;
        room = {1'b0, sel_mask} + 17'h00001 - {1'b0, off};
    end

    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc_phys_o <= 24'h000000;
            acc_first_len_o <= 16'h0000;
            acc_wraps_o <= 1'b0;
        end
        else
        begin
            // (RL16) base plus masked pointer
            acc_phys_o <= sel_base + {8'h00, off};
            // (RL17) split at top, wrap to base
            if ({1'b0, acc_len_i} > room)
            begin
                acc_first_len_o <= room[15:0];
                acc_wraps_o <= 1'b1;
            end
            else
            begin
                acc_first_len_o <= acc_len_i;
                acc_wraps_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Network settings and socket behaviour
    // ------------------------------------------------------------
    reg [15:0] interval_ff;
    reg [7:0] attempts_ff;
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            local_hw_addr_o <= 48'h000000000000;
            gateway_ip_o <= 32'h00000000;
            netmask_o <= 32'h00000000;
            local_ip_o <= 32'h00000000;
            core_irq_threshold_o <= `SBN_IRQ_THRESHOLD_RST;
            interval_ff <= `SBN_RETRY_INTERVAL_RST;
            attempts_ff <= `SBN_RETRY_ATTEMPTS_RST;
            init_done_o <= 1'b0;
            echo_reply_o <= 1'b0;
            conn_accept_o <= 8'h00;
            conn_req_tx_o <= 8'h00;
        end
        else
        begin
            if (net_load_i)
            begin
                local_hw_addr_o <= local_hw_addr_i;
                gateway_ip_o <= gateway_ip_i;
                netmask_o <= netmask_i;
                local_ip_o <= local_ip_i;
                core_irq_threshold_o <= core_irq_threshold_i;
                interval_ff <= retry_interval_i;
                attempts_ff <= retry_attempts_i;
            end
            if (net_load_i || cfg_load_i)
                init_done_o <= 1'b1;
            // (RL12) automatic echo reply
            echo_reply_o <= init_done_o && echo_req_i;
            // (RL11) independent per-socket handling
            // (RL13) server accepts incoming request
            conn_accept_o <= sock_open_i & sock_server_i & conn_req_rx_i;
            // (RL14) client sends request on open
            conn_req_tx_o <= sock_open_i & ~sock_server_i;
        end
    end

    // ------------------------------------------------------------
    // Retransmission control
    // ------------------------------------------------------------
    localparam [4:0] ST_IDLE = `SBN_ST_IDLE;
    localparam [4:0] ST_WAIT = `SBN_ST_WAIT;
    localparam [4:0] ST_RESEND = `SBN_ST_RESEND;
    reg [4:0] state_ff;
    reg [4:0] nxt_state;
    reg [7:0] tries_ff;
    reg [7:0] nxt_tries;
    wire timer_expired;
    wire timer_start = (state_ff == ST_IDLE && tx_fail_i) || (state_ff == ST_RESEND);

    sbn_retry_timer u_timer (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(timer_start),
        .interval_i(interval_ff),
        .expired_o(timer_expired)
    );

    // (RL8) bounded retry sequence
    always @*
    begin
        nxt_state = state_ff;
        nxt_tries = tries_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (tx_fail_i)
                begin
                    nxt_state = ST_WAIT;
                    nxt_tries = 8'h00;
                end
            end
            ST_WAIT:
            begin
                if (tx_ok_i)
                    nxt_state = ST_IDLE;
                else if (timer_expired)
                begin
                    if (tries_ff >= attempts_ff)
                        nxt_state = ST_IDLE;
                    else
                    begin
                        nxt_state = ST_RESEND;
                        nxt_tries = tries_ff + 8'h01;
                    end
                end
            end
            ST_RESEND:
                nxt_state = ST_WAIT;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= ST_IDLE;
            tries_ff <= 8'h00;
            resend_o <= 1'b0;
            retry_fail_o <= 1'b0;
            retry_busy_o <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            tries_ff <= nxt_tries;
            resend_o <= (nxt_state == ST_RESEND);
            retry_fail_o <= (state_ff == ST_WAIT) && !tx_ok_i && timer_expired && (tries_ff >= attempts_ff);
            retry_busy_o <= (nxt_state != ST_IDLE);
        end
    end
endmodule // sbn_core

// ==== src/sbn_map.vh ====
// Constants of the socket buffer and network configuration block.
// Assumes inclusion by bare name from the design sources.
`ifndef SBN_MAP_VH
`define SBN_MAP_VH
`define SBN_NUM_SOCK 8
`define SBN_TX_REGION_BASE 24'hfe8000
`define SBN_RX_REGION_BASE 24'hfec000
`define SBN_REGION_BYTES 17'h04000
`define SBN_SIZE_CODE_W 3
`define SBN_SIZE_1K 3'h1
`define SBN_SIZE_2K 3'h2
`define SBN_SIZE_4K 3'h4
`define SBN_SIZE_8K 3'h0
`define SBN_SIZE_16K 3'h0
`define SBN_SIZE_RST 8'h02
`define SBN_RETRY_UNIT_NS 100000
`define SBN_CLK_PERIOD_NS 40
// One 100 us retry unit at the 40 ns system clock.
`define SBN_RETRY_UNIT_CYC 12'h9c4
`define SBN_RETRY_INTERVAL_RST 16'h07d0
`define SBN_RETRY_ATTEMPTS_RST 8'h08
`define SBN_IRQ_THRESHOLD_RST 16'h0000
`define SBN_ST_IDLE 5'h01
`define SBN_ST_WAIT 5'h02
`define SBN_ST_RESEND 5'h04
`define SBN_ST_DONE 5'h08
`define SBN_ST_FAIL 5'h10
`endif

// ==== src/sbn_retry_timer.v ====
// Retransmission timer: waits one retry interval per attempt, counted in 100 us units.
// Assumes a 25 MHz clock and an interval value held steady while a retry sequence runs.
`include "sbn_map.vh"
module sbn_retry_timer (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // Control
    input wire start_i,
    input wire [15:0] interval_i,
    // Result
    output wire expired_o
);
    localparam [11:0] UNIT_CYC = `SBN_RETRY_UNIT_CYC;
    reg [11:0] unit_cnt_ff;
    reg [15:0] tick_cnt_ff;
    reg run_ff;
    reg expired_ff;
    assign expired_o = expired_ff;
    // (RL7) 100 us units
    always @(posedge sys_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            unit_cnt_ff <= 12'h000;
            tick_cnt_ff <= 16'h0000;
            run_ff <= 1'b0;
            expired_ff <= 1'b0;
        end
        else
        begin
            expired_ff <= 1'b0;
            if (start_i)
            begin
                unit_cnt_ff <= 12'h000;
                tick_cnt_ff <= 16'h0000;
                run_ff <= 1'b1;
            end
            else if (run_ff)
            begin
                if (unit_cnt_ff == UNIT_CYC - 12'h001)
                begin
                    unit_cnt_ff <= 12'h000;
                    if (tick_cnt_ff + 16'h0001 >= interval_i)
                    begin
                        run_ff <= 1'b0;
                        expired_ff <= 1'b1;
                    end
                    else
                    begin
                        tick_cnt_ff <= tick_cnt_ff + 16'h0001;
                    end
                end
                else
                begin
                    unit_cnt_ff <= unit_cnt_ff + 12'h001;
                end
            end
        end
    end
endmodule // sbn_retry_timer

// ==== bench/sbn_link_model.sv ====
// Far-end link model: reports how each send of the core ends.
// Assumes the bench kicks a send only while retry control is idle.
module sbn_link_model (
    // Clock and reset
    input wire sys_clk_i,
    input wire rst_n_i,
    // Bench and core controls
    input wire kick_i,
    input wire ok_mode_i,
    input wire resend_i,
    // Send outcome
    output reg tx_fail_o,
    output reg tx_ok_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A resend only succeeds in ok mode, so the give-up path can be reached.
    always @(posedge sys_clk_i or negedge rst_n_i)
        if (!rst_n_i)
        begin
            tx_fail_o <= 1'b0;
            tx_ok_o <= 1'b0;
        end
        else
        begin
            tx_fail_o <= kick_i;
            tx_ok_o <= resend_i & ok_mode_i;
        end
endmodule // sbn_link_model

// ==== bench/sbn_core_sva.sv ====
// Checker for the ports of sbn_core.
// Assumes one 25 MHz clock and the bind at the foot of this file.
module sbn_core_chk (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire [2:0] acc_sock_i,
    input wire acc_is_rx_i,
    input wire [15:0] acc_ptr_i,
    input wire [15:0] acc_len_i,
    input wire [23:0] acc_phys_o,
    input wire acc_wraps_o,
    input wire [191:0] sock_tx_base_o,
    input wire [191:0] sock_rx_base_o,
    input wire [127:0] sock_tx_offset_mask_o,
    input wire [127:0] sock_rx_offset_mask_o,
    input wire init_done_o,
    input wire echo_req_i,
    input wire echo_reply_o,
    input wire [7:0] sock_open_i,
    input wire [7:0] sock_server_i,
    input wire [7:0] conn_req_rx_i,
    input wire [7:0] conn_accept_o,
    input wire [7:0] conn_req_tx_o,
    input wire tx_fail_i,
    input wire resend_o,
    input wire retry_busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] msk;
    logic [23:0] e_phys;
    logic e_wrap;
    logic pk;
    logic [16:0] gap_ff;
    always @*
    begin
        msk = acc_is_rx_i ? sock_rx_offset_mask_o[acc_sock_i*16+:16] : sock_tx_offset_mask_o[acc_sock_i*16+:16];
        e_phys = (acc_is_rx_i ? sock_rx_base_o[acc_sock_i*24+:24] : sock_tx_base_o[acc_sock_i*24+:24]);
        e_phys = e_phys + {8'h00, acc_ptr_i & msk};
        e_wrap = ({1'b0, acc_ptr_i & msk} + {1'b0, acc_len_i}) > ({1'b0, msk} + 17'h00001);
        pk = 1'b1;
        for (int g = 1; g < 8; g++)
            pk = pk & (sock_tx_base_o[g*24+:24] == sock_tx_base_o[g*24-24+:24] + sock_tx_offset_mask_o[g*16-16+:16] + 24'h1)
                & (sock_rx_base_o[g*24+:24] == sock_rx_base_o[g*24-24+:24] + sock_rx_offset_mask_o[g*16-16+:16] + 24'h1);
    end
    // Cycles since retry went busy or since the last resend.
    always @(posedge sys_clk_i or negedge rst_n_i)
        if (!rst_n_i)
            gap_ff <= 17'h00000;
        else if (resend_o || !retry_busy_o)
            gap_ff <= 17'h00000;
        else if (gap_ff != 17'h1ffff)
            gap_ff <= gap_ff + 17'h00001;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_fail_taken; tx_fail_i && !retry_busy_o; endsequence
    sequence s_busy_wait; (retry_busy_o && !resend_o) [*8]; endsequence
    a_tx_region_base: assert property (sock_tx_base_o[23:0] == 24'hfe8000) else $error("tx region base wrong");
    a_rx_region_base: assert property (sock_rx_base_o[23:0] == 24'hfec000) else $error("rx region base wrong");
    a_bases_packed: assert property (pk) else $error("socket bases not packed");
    a_mask_shape: assert property ($onehot(sock_tx_offset_mask_o[15:0] + 16'h1) &&
        sock_tx_offset_mask_o[15:0] >= 16'h03ff && sock_rx_offset_mask_o[15:0] <= 16'h3fff)
        else $error("offset mask shape wrong");
    a_phys_addr: assert property ($past(rst_n_i) |-> acc_phys_o == $past(e_phys)) else $error("physical address wrong");
    a_wrap_flag: assert property ($past(rst_n_i) |-> acc_wraps_o == $past(e_wrap)) else $error("wrap flag wrong");
    a_echo_reply: assert property (echo_req_i && init_done_o |=> echo_reply_o) else $error("echo not answered");
    a_echo_cause: assert property (echo_reply_o |-> $past(echo_req_i)) else $error("echo reply without request");
    a_passive_accept: assert property ($past(rst_n_i) |->
        conn_accept_o == $past(sock_open_i & sock_server_i & conn_req_rx_i)) else $error("accept wrong");
    a_active_open: assert property ($past(rst_n_i) |->
        conn_req_tx_o == $past(sock_open_i & ~sock_server_i)) else $error("connect request wrong");
    a_retry_start: assert property (s_fail_taken |=> s_busy_wait) else $error("retry wait did not start");
    a_retry_gap: assert property (resend_o |-> gap_ff >= 17'h00960) else $error("resend too early");
endmodule // sbn_core_chk
bind sbn_core sbn_core_chk u_sbn_core_chk (.*);

// ==== bench/testbench.sv ====
// Self-checking bench for sbn_core.
// Assumes the link model and the bound checker are compiled before it.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, cfg_ld = 0, net_ld = 0, echo = 0, is_rx = 0, kick = 0, ok_m = 0;
    logic [63:0] txs = 64'h0202020202020202, rxs = 64'h0202020202020202;
    logic [2:0] sk = 0;
    logic [15:0] ptr = 0, len = 0, rti = 0, thi = 0;
    logic [7:0] op = 0, srv = 0, syn = 0, rci = 0;
    logic [47:0] hwi = 0;
    logic [31:0] gwi = 0, nmi = 0, ipi = 0;
    wire [23:0] phys;
    wire [15:0] flen, thr;
    wire [191:0] tb, rb;
    wire [127:0] tm, rm;
    wire [47:0] hw;
    wire [31:0] gw, nm, ip;
    wire [7:0] acc, ctx, serr;
    wire [1:0] terr;
    wire wr, idn, rep, fl, ok, rs, rf, bsy;
    int error_cnt = 0, total_checks = 0;
    // Reload that firmware would put in timer 2 for 115200 baud; nothing in this block consumes it.
    localparam int T2_RELOAD = 65536 - 88473600 / (32 * 115200);
    always #20 clk = ~clk;
    sbn_core u_sbn_core (.sys_clk_i(clk), .rst_n_i(rst_n), .sock_tx_buf_size_i(txs), .sock_rx_buf_size_i(rxs),
        .cfg_load_i(cfg_ld), .acc_sock_i(sk), .acc_is_rx_i(is_rx), .acc_ptr_i(ptr), .acc_len_i(len),
        .acc_phys_o(phys), .acc_first_len_o(flen), .acc_wraps_o(wr), .sock_tx_base_o(tb), .sock_rx_base_o(rb),
        .sock_tx_offset_mask_o(tm), .sock_rx_offset_mask_o(rm), .size_err_o(serr), .total_err_o(terr),
        .local_hw_addr_i(hwi), .gateway_ip_i(gwi), .netmask_i(nmi), .local_ip_i(ipi), .retry_interval_i(rti),
        .retry_attempts_i(rci), .core_irq_threshold_i(thi), .net_load_i(net_ld), .local_hw_addr_o(hw),
        .gateway_ip_o(gw), .netmask_o(nm), .local_ip_o(ip), .core_irq_threshold_o(thr), .init_done_o(idn),
        .echo_req_i(echo), .echo_reply_o(rep), .sock_open_i(op), .sock_server_i(srv), .conn_req_rx_i(syn),
        .conn_accept_o(acc), .conn_req_tx_o(ctx), .tx_fail_i(fl), .tx_ok_i(ok), .resend_o(rs),
        .retry_fail_o(rf), .retry_busy_o(bsy));
    sbn_link_model u_sbn_link_model (.sys_clk_i(clk), .rst_n_i(rst_n), .kick_i(kick), .ok_mode_i(ok_m),
        .resend_i(rs), .tx_fail_o(fl), .tx_ok_o(ok));
    task automatic chk(input string n, input logic [47:0] e, input logic [47:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Loads sizes, then walks all eight sockets of both regions.
    task automatic t_layout(input logic [63:0] ts, input logic [63:0] rz);
        logic [23:0] bt, br;
        txs = ts;
        rxs = rz;
        cfg_ld = 1;
        step(1);
        cfg_ld = 0;
        step(1);
        bt = 24'hfe8000;
        br = 24'hfec000;
        for (int g = 0; g < 8; g++)
        begin
            chk("tx_base", bt, tb[g*24+:24]);
            chk("rx_base", br, rb[g*24+:24]);
            chk("tx_mask", {ts[g*8+:8], 10'h000} - 18'h1, tm[g*16+:16]);
            chk("rx_mask", {rz[g*8+:8], 10'h000} - 18'h1, rm[g*16+:16]);
            bt = bt + {ts[g*8+:8], 10'h000};
            br = br + {rz[g*8+:8], 10'h000};
        end
        chk("size_err", 8'h00, serr);
    endtask
    task automatic t_acc(input logic [15:0] p, input logic [15:0] l, input logic [23:0] e, input logic [15:0] f);
        ptr = p;
        len = l;
        step(2);
        chk("phys", e, phys);
        chk("first_len", f, flen);
        chk("wraps", f != l, wr);
    endtask
    // A send that keeps failing must give up after the attempt count; one that recovers must not.
    task automatic t_retry(input logic m);
        int c, n;
        ok_m = m;
        kick = 1;
        step(1);
        kick = 0;
        c = 0;
        n = 0;
        while (!rs && c < 3000)
        begin
            step(1);
            c++;
        end
        chk("retry_gap", 1, c >= 2500 && c <= 2506);
        for (int i = 0; i < 8000 && !rf && bsy !== 0; i++)
        begin
            n += rs;
            step(1);
        end
        chk("retry_fail", !m, rf);
        chk("resends", m ? 1 : 2, n);
        step(2);
        chk("busy", 0, bsy);
    endtask
    initial
    begin
        #(40ns * 40000);
        error_cnt++;
        end_sim();
    end
    initial
    begin
        step(12);
        rst_n = 1;
        chk("init_done", 0, idn);
        chk("rst_tx_base7", 24'hfeb800, tb[191:168]);
        chk("rst_rx_mask7", 16'h07ff, rm[127:112]);
        echo = 1;
        step(1);
        echo = 0;
        chk("echo_early", 0, rep);
        t_layout(txs, rxs);
        chk("init_done", 1, idn);
        t_layout(64'h0201010101020404, 64'h0201010101010108);
        is_rx = 1;
        sk = 1;
        t_acc(16'h0ffe, 16'h0004, 24'hfee3fe, 16'h0002);
        sk = 7;
        t_acc(16'h0010, 16'h0010, 24'hfef810, 16'h0010);
        hwi = 48'h02a0b0c0d0e0;
        thi = 16'h2b00;
        rti = 16'h0001;
        rci = 8'h02;
        gwi = 32'hc0a80001;
        nmi = 32'hffffff00;
        ipi = 32'hc0a80002;
        net_ld = 1;
        step(1);
        net_ld = 0;
        echo = 1;
        step(1);
        echo = 0;
        chk("echo_reply", 1, rep);
        chk("hw_addr", hwi, hw);
        chk("irq_thr", thi, thr);
        chk("net", {gwi, nmi[15:0]}, {gw, nm[15:0]});
        chk("netmask", nmi, nm);
        chk("ip", ipi, ip);
        op = 8'hff;
        srv = 8'h0f;
        syn = 8'h05;
        step(2);
        chk("accept", 8'h05, acc);
        chk("conn_req", 8'hf0, ctx);
        t_retry(0);
        t_retry(1);
        t_layout(64'h0101010101010110, rxs);
        chk("overcommit_tx", 2'h1, terr);
        t_layout(64'h0101010101010110, 64'h0101010101010110);
        chk("overcommit_both", 2'h3, terr);
        txs = 64'h0202020202020203;
        cfg_ld = 1;
        step(1);
        cfg_ld = 0;
        step(1);
        chk("size_err", 8'h01, serr);
        chk("bad_size_mask", 16'h03ff, tm[15:0]);
        end_sim();
    end
endmodule // testbench
